/* File: rtl/pfm_defines.svh */
// Offsets, field positions and reset values of the port 0 function mux
`ifndef PFM_DEFINES_SVH
`define PFM_DEFINES_SVH
`define PFM_NBITS 10
`define PFM_OFS_DATA 12'h000
`define PFM_OFS_CFG0 12'h004
`define PFM_OFS_CFG1 12'h008
`define PFM_OFS_CFG2 12'h00C
`define PFM_OFS_BOOT 12'h010
`define PFM_OFS_PIN 12'h014
`define PFM_RST_CFG0 10'h3FF
`define PFM_RST_CFG1 10'h3FF
`define PFM_RST_CFG2 10'h000
`define PFM_RST_DATA 10'h0FF
`define PFM_BOOT_SPI_EN 0
`define PFM_BOOT_SEL 1
`define PFM_PIN_UART_RX 8
`define PFM_PIN_BOOT 9
`define PFM_PIN_SHARED_LO 0
`define PFM_PIN_SHARED_HI 3
`endif

/* File: rtl/pfm_pkg.sv */
// Types of the port 0 function mux
package pfm_pkg;
    typedef enum logic [2:0]
    {
        PFM_ANALOG,
        PFM_IN_TTL,
        PFM_IN_CMOS,
        PFM_IN_PUPD,
        PFM_OUT_OD,
        PFM_OUT_PP,
        PFM_AF_OD,
        PFM_AF_PP
    } pfm_mode_t;
endpackage

/* File: rtl/pfm_pin_cell.sv */
// One port pin: mode decode, drive, pull and read-back
`timescale 1ns/1ps
`include "pfm_defines.svh"
module pfm_pin_cell
(
    // Configuration
    input wire logic cfg0_i,
    input wire logic cfg1_i,
    input wire logic cfg2_i,
    input wire logic data_i,
    // Alternate function
    input wire logic af_out_i,
    input wire logic af_oe_i,
    // Pin
    input wire logic pin_i,
    output logic out_o,
    output logic oe_o,
    output logic pu_o,
    output logic pd_o,
    output logic rd_o
);
    import pfm_pkg::*;
    pfm_mode_t mode;
    always_comb
    begin
        mode = pfm_mode_t'({cfg2_i, cfg1_i, cfg0_i});
        out_o = 1'b0;
        oe_o = 1'b0;
        pu_o = 1'b0;
        pd_o = 1'b0;
        rd_o = pin_i;
        case (mode)
            PFM_ANALOG: rd_o = 1'b0;
            PFM_IN_PUPD:
            begin
                pu_o = data_i;
                pd_o = ~data_i;
            end
            PFM_OUT_OD: oe_o = ~data_i;
            PFM_OUT_PP:
            begin
                out_o = data_i;
                oe_o = 1'b1;
                rd_o = data_i;
            end
            PFM_AF_OD: oe_o = af_oe_i & ~af_out_i;
            PFM_AF_PP:
            begin
                out_o = af_out_i;
                oe_o = af_oe_i;
            end
            default: rd_o = pin_i;
        endcase
    end
endmodule

/* File: rtl/pfm_port0_mux.sv */
// Port 0 pin function mux with APB register access
// Function
// - After reset every port bit is in input pull-up/pull-down mode (cfg0=1, cfg1=1, cfg2=0).
// - Data bits reset to pick the pull: bits 0 to 7 pull up, bits 8 and 9 pull down.
// - Shared pins 0, 2 and 3 go to the async serial or two-wire port unless the sync port enable is set; pin 1 then has no owner.
// - The serial 0 receive pin in alternate push-pull output is tri-stated except while sending.
// - In pull mode a data bit of one picks pull-up, zero pull-down; reads give the pin.
// - In push-pull output mode a data read returns the output latch.
`timescale 1ns/1ps
`include "pfm_defines.svh"
module pfm_port0_mux
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic [9:0] pin_i,
    output logic [9:0] pin_o,
    output logic [9:0] pin_oe_o,
    output logic [9:0] pull_up_o,
    output logic [9:0] pull_down_o,
    // Sync serial port
    input wire logic spi_miso_out_i,
    input wire logic spi_miso_oe_i,
    input wire logic spi_mosi_out_i,
    input wire logic spi_mosi_oe_i,
    input wire logic spi_sclk_out_i,
    input wire logic spi_sclk_oe_i,
    // Async serial 3
    input wire logic serial3_transmit_i,
    // Two-wire 1, open-drain drive lows
    input wire logic twowire1_clock_low_i,
    input wire logic twowire1_data_low_i,
    // Async serial 0
    input wire logic serial0_transmit_i,
    input wire logic serial0_tx_busy_i,
    // Boot select level
    output logic boot_select_o
);
    import pfm_pkg::*;

    logic [9:0] cfg0, cfg1, cfg2, data;
    logic [1:0] boot_config_register;
    logic [9:0] next_cfg0, next_cfg1, next_cfg2, next_data;
    logic [1:0] next_boot;
    logic [9:0] af_out, af_oe, cell_out, cell_oe, cell_pu, cell_pd, cell_rd;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic acc, wr, hit;
    logic spi_en;

    assign spi_en = boot_config_register[`PFM_BOOT_SPI_EN];

    // Alternate function owner per pin
    always_comb
    begin
        af_out = 10'h000;
        af_oe = 10'h000;
        if (spi_en)
        begin
            af_out[0] = spi_miso_out_i;
            af_oe[0] = spi_miso_oe_i;
            af_out[1] = spi_mosi_out_i;
            af_oe[1] = spi_mosi_oe_i;
            af_out[2] = spi_sclk_out_i;
            af_oe[2] = spi_sclk_oe_i;
            af_out[3] = 1'b1;
            af_oe[3] = 1'b0;
        end
        else
        begin
            af_out[0] = serial3_transmit_i;
            af_oe[0] = 1'b1;
            af_out[2] = 1'b0;
            af_oe[2] = twowire1_clock_low_i;
            af_out[3] = 1'b0;
            af_oe[3] = twowire1_data_low_i;
        end
        // Slave 1 pins 4..7 are inputs or driven by the sync port 1 outside
        af_out[8] = serial0_transmit_i;
        af_oe[8] = serial0_tx_busy_i;
        af_out[9] = serial0_transmit_i;
        af_oe[9] = 1'b1;
    end

    genvar gi;
    generate
        for (gi = 0; gi < `PFM_NBITS; gi++)
        begin : g_pin
            pfm_pin_cell u_cell
            (
                .cfg0_i(cfg0[gi]),
                .cfg1_i(cfg1[gi]),
                .cfg2_i(cfg2[gi]),
                .data_i(data[gi]),
                .af_out_i(af_out[gi]),
                .af_oe_i(af_oe[gi]),
                .pin_i(pin_i[gi]),
                .out_o(cell_out[gi]),
                .oe_o(cell_oe[gi]),
                .pu_o(cell_pu[gi]),
                .pd_o(cell_pd[gi]),
                .rd_o(cell_rd[gi])
            );
        end
    endgenerate

    // APB: registered answer after one wait state
    always_comb
    begin
        acc = psel & penable & ~pready;
        // Write lands on the edge where the master sees pready high
        wr = psel & penable & pready & pwrite;
        next_cfg0 = cfg0;
        next_cfg1 = cfg1;
        next_cfg2 = cfg2;
        next_data = data;
        next_boot = boot_config_register;
        next_prdata = 32'h0000_0000;
        hit = 1'b1;
        case (paddr)
            `PFM_OFS_DATA:
            begin
                next_prdata = {22'h000000, cell_rd};
                if (wr) next_data = pwdata[9:0];
            end
            `PFM_OFS_CFG0:
            begin
                next_prdata = {22'h000000, cfg0};
                if (wr) next_cfg0 = pwdata[9:0];
            end
            `PFM_OFS_CFG1:
            begin
                next_prdata = {22'h000000, cfg1};
                if (wr) next_cfg1 = pwdata[9:0];
            end
            `PFM_OFS_CFG2:
            begin
                next_prdata = {22'h000000, cfg2};
                if (wr) next_cfg2 = pwdata[9:0];
            end
            `PFM_OFS_BOOT:
            begin
                next_prdata = {30'h00000000, boot_config_register};
                if (wr) next_boot[`PFM_BOOT_SPI_EN] = pwdata[`PFM_BOOT_SPI_EN];
            end
            `PFM_OFS_PIN: next_prdata = {22'h000000, pin_i};
            default: hit = 1'b0;
        endcase
        if (!acc)
            next_prdata = prdata;
        next_pready = acc;
        next_pslverr = acc & ~hit;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            cfg0 <= `PFM_RST_CFG0;
            cfg1 <= `PFM_RST_CFG1;
            cfg2 <= `PFM_RST_CFG2;
            data <= `PFM_RST_DATA;
            boot_config_register <= 2'h0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            pin_o <= 10'h000;
            pin_oe_o <= 10'h000;
            pull_up_o <= 10'h0FF;
            pull_down_o <= 10'h300;
            boot_select_o <= 1'b0;
        end
        else
        begin
            cfg0 <= next_cfg0;
            cfg1 <= next_cfg1;
            cfg2 <= next_cfg2;
            data <= next_data;
            // Boot strap level on bit 9 captured every cycle
            boot_config_register <= {pin_i[`PFM_PIN_BOOT], next_boot[0]};
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            // Outputs registered: one cycle behind config changes
            pin_o <= cell_out;
            pin_oe_o <= cell_oe;
            pull_up_o <= cell_pu;
            pull_down_o <= cell_pd;
            boot_select_o <= pin_i[`PFM_PIN_BOOT];
        end
    end

    // Assertions
    reset_cfg_a: assert property (@(posedge clk_sys_i) $past(sys_rst_i) |->
        (cfg0 == 10'h3FF && cfg1 == 10'h3FF && cfg2 == 10'h000))
        else $error("Port config wrong after reset");
    reset_pull_a: assert property (@(posedge clk_sys_i) $past(sys_rst_i) |->
        (pull_up_o == 10'h0FF && pull_down_o == 10'h300))
        else $error("Reset pulls wrong");
    spi_owner_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (!spi_en && cfg2[0] && cfg1[0] && cfg0[0])
        |=> (pin_oe_o[0] && pin_o[0] == $past(serial3_transmit_i)))
        else $error("Shared pin not owned by async port");
    rx_tristate_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (cfg2[8] && cfg1[8] && cfg0[8] && !serial0_tx_busy_i) |=> !pin_oe_o[8])
        else $error("Receive pin driven while idle");
    boot_pin_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        1'b1 |=> boot_select_o == $past(pin_i[9]))
        else $error("Boot select not tracking pin");
    pull_sel_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (cfg0[1] && cfg1[1] && !cfg2[1]) |=> pull_up_o[1] == $past(data[1]))
        else $error("Pull direction wrong");
    latch_read_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (acc && !pwrite && paddr == `PFM_OFS_DATA && cfg2[0] && !cfg1[0] && cfg0[0])
        |=> prdata[0] == $past(data[0]))
        else $error("Push-pull read not from latch");
endmodule

/* File: verification/pfm_serial_peer.sv */
// Far-side devices on port 0 seen as resolved pin levels
`timescale 1ns/1ps
module pfm_serial_peer
(
    // Clock
    input wire logic clk_sys_i,
    // Device drive and pulls
    input wire logic [9:0] pin_o,
    input wire logic [9:0] pin_oe_o,
    input wire logic [9:0] pull_up_o,
    input wire logic [9:0] pull_down_o,
    // Lines held to ground by a far-side device
    input wire logic [9:0] short_low_i,
    // Resolved levels
    output logic [9:0] pin_i
);
    logic [9:0] float_pat = 10'h155;
    // Released and unpulled pins wander so a stale level never reads as valid
    always_ff @(posedge clk_sys_i)
    begin
        float_pat <= ~float_pat;
    end
    // A grounded line wins over any drive, so pin reads differ from the latch
    assign pin_i = ((pin_oe_o & pin_o) | (~pin_oe_o & pull_up_o)
        | (~pin_oe_o & ~pull_up_o & ~pull_down_o & float_pat)) & ~short_low_i;
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench of the port 0 function mux
`timescale 1ns/1ps
`include "pfm_defines.svh"
module tb_top;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [9:0] pin_i;
    logic [9:0] pin_o;
    logic [9:0] pin_oe_o;
    logic [9:0] pull_up_o;
    logic [9:0] pull_down_o;
    logic boot_select_o;
    logic miso_out = 1'b0;
    logic miso_oe = 1'b0;
    logic s3_tx = 1'b0;
    logic scl_low = 1'b0;
    logic sda_low = 1'b0;
    logic sclk_oe = 1'b0;
    logic [9:0] pin_short = 10'h000;
    logic s0_tx = 1'b0;
    logic s0_busy = 1'b0;
    int error_cnt = 0;
    int n_compared = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    pfm_port0_mux i_pfm_port0_mux (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .pull_up_o(pull_up_o), .pull_down_o(pull_down_o),
        .spi_miso_out_i(miso_out), .spi_miso_oe_i(miso_oe), .spi_mosi_out_i(1'b0),
        .spi_mosi_oe_i(1'b0), .spi_sclk_out_i(1'b0), .spi_sclk_oe_i(sclk_oe),
        .serial3_transmit_i(s3_tx), .twowire1_clock_low_i(scl_low),
        .twowire1_data_low_i(sda_low), .serial0_transmit_i(s0_tx),
        .serial0_tx_busy_i(s0_busy), .boot_select_o(boot_select_o));
    pfm_serial_peer i_pfm_serial_peer (.clk_sys_i(clk_sys_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .pull_up_o(pull_up_o), .pull_down_o(pull_down_o),
        .short_low_i(pin_short), .pin_i(pin_i));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys_i);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20)
        begin
            chk(32'h0, 32'h1);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, 32'h0);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk({22'h0, r[9:0]}, exp);
    endtask
    task automatic settle();
        repeat (3) @(posedge clk_sys_i);
    endtask
    task automatic t_reset();
        chk(pull_up_o, 10'h0FF);
        chk(pull_down_o, 10'h300);
        chk(pin_oe_o, 10'h000);
        rdc(`PFM_OFS_CFG0, 10'h3FF);
        rdc(`PFM_OFS_CFG1, 10'h3FF);
        rdc(`PFM_OFS_CFG2, 10'h000);
        rdc(`PFM_OFS_DATA, 10'h0FF);
        chk(boot_select_o, 1'b0);
        $display("reset test done");
    endtask
    task automatic t_pull();
        logic [31:0] r;
        logic e;
        wr(`PFM_OFS_DATA, 32'h2A5);
        settle();
        chk(pull_up_o, 10'h2A5);
        chk(pull_down_o, 10'h15A);
        rdc(`PFM_OFS_PIN, 10'h2A5);
        chk(boot_select_o, 1'b1);
        pin_short <= 10'h001;
        rdc(`PFM_OFS_DATA, 10'h2A4);
        pin_short <= 10'h000;
        apb(1'b1, 12'h0FC, 32'h0, r, e);
        chk(e, 1'b1);
        $display("pull test done");
    endtask
    task automatic t_pp();
        wr(`PFM_OFS_CFG1, 32'h0);
        wr(`PFM_OFS_CFG2, 32'h3FF);
        wr(`PFM_OFS_DATA, 32'h0C3);
        settle();
        chk(pin_oe_o, 10'h3FF);
        chk(pin_o, 10'h0C3);
        rdc(`PFM_OFS_DATA, 10'h0C3);
        pin_short <= 10'h001;
        rdc(`PFM_OFS_DATA, 10'h0C3);
        rdc(`PFM_OFS_PIN, 10'h0C2);
        pin_short <= 10'h000;
        $display("push-pull test done");
    endtask
    task automatic t_af();
        s3_tx <= 1'b1;
        s0_tx <= 1'b1;
        scl_low <= 1'b1;
        sda_low <= 1'b1;
        wr(`PFM_OFS_CFG1, 32'h3FF);
        settle();
        chk({pin_oe_o[9:8], pin_o[9]}, 3'b101);
        chk({pin_oe_o[0], pin_o[0], pin_oe_o[2], pin_o[2]}, 4'b1110);
        chk({pin_oe_o[3], pin_o[3]}, 2'b10);
        s0_busy <= 1'b1;
        settle();
        chk({pin_oe_o[8], pin_o[8]}, 2'b11);
        wr(`PFM_OFS_BOOT, 32'h1);
        settle();
        chk({pin_oe_o[0], pin_oe_o[2], pin_oe_o[3]}, 3'b000);
        miso_oe <= 1'b1;
        sclk_oe <= 1'b1;
        settle();
        chk({pin_oe_o[0], pin_o[0], pin_oe_o[2]}, 3'b101);
        $display("alternate function test done");
    endtask
    task automatic t_rerst();
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        chk(pin_oe_o, 10'h000);
        chk(pull_up_o, 10'h0FF);
        chk(pull_down_o, 10'h300);
        rdc(`PFM_OFS_CFG1, 10'h3FF);
        rdc(`PFM_OFS_CFG2, 10'h000);
        rdc(`PFM_OFS_BOOT, 10'h000);
        $display("mid-run reset test done");
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        t_reset();
        t_pull();
        t_pp();
        t_af();
        t_rerst();
        close_out();
    end
    initial
    begin
        #20000;
        error_cnt++;
        close_out();
    end
endmodule
